// ### hw/phy_event_interrupt_status.sv
// Event status, enables and interrupt pin control of the transceiver
//
// Notes on behaviour
// - Flag set if event since last read
// - Enabled pending event raises interrupt
// - Global control register must also permit
// - Flags set even when interrupt disabled
// - Bit 15 link quality pending, clear-on-read
// - Bit 14 energy detect pending, clear-on-read
// - Bit 13 link change pending, clear-on-read
// - Bit 12 speed change pending, clear-on-read
// - Bit 11 duplex change, when control bit3 zero
// - Bit 10 autoneg complete pending, clear-on-read
// - Selectors zero: bit 9 false carrier half
// - Selector set: bit 9 either counter half
// - Selectors zero: bit 8 receive error half
// - Selector set: bit 8 control frame
// - Bit 7 enables link quality interrupt
// - Bit 6 enables energy detect interrupt
// - Bit 5 enables link change interrupt
// - Bits 4..0 enable remaining events, reset zero
// - Global event enable is control bit 1
// - Control bit 0 turns pin into output
// - Test bit forces interrupt while set
`timescale 1ns/1ps
`include "phy_irq_cfg.svh"

module phy_event_interrupt_status (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // Management register port
   input wire logic [`ADDR_W-1:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [`REG_W-1:0] REG_WDATA_I,
   output logic [`REG_W-1:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   // Selector field of the second PHY control register
   input wire logic [`CTRL2_SEL_W-1:0] PHY_CONTROL_TWO_SEL_I,
   // Event pulses from the monitors
   input wire logic LINK_QUALITY_EVT_I,
   input wire logic ENERGY_DETECT_EVT_I,
   input wire logic LINK_CHANGE_EVT_I,
   input wire logic SPEED_CHANGE_EVT_I,
   input wire logic DUPLEX_CHANGE_EVT_I,
   input wire logic AUTONEG_DONE_EVT_I,
   input wire logic FALSE_CARRIER_HALF_EVT_I,
   input wire logic RX_ERROR_HALF_EVT_I,
   input wire logic CONTROL_FRAME_EVT_I,
   // Shared power-down / interrupt pin
   input wire logic POWERDOWN_OR_IRQ_PIN_N_I,
   output logic POWERDOWN_OR_IRQ_PIN_N_O,
   output logic POWERDOWN_OR_IRQ_PIN_OE_O,
   output logic POWER_DOWN_REQ_O,
   output logic IRQ_O
);

   // ****************************************************************
   // State
   // ****************************************************************
   phy_irq_pkg::ctrl_state_t s_q;
   phy_irq_pkg::ctrl_state_t s_d;

   logic [`EVT_COUNT-1:0] pending;
   logic [`EVT_COUNT-1:0] event_set;
   logic [`EVT_COUNT-1:0] event_clear;
   logic [`EVT_COUNT-1:0] pending_next;

   logic hit_status;
   logic hit_control;
   logic rd_status;
   logic wr_status;
   logic wr_control;
   logic duplex_selected;
   logic shared_sel;
   logic any_enabled_pending;
   logic [`REG_W-1:0] status_word;
   logic [`REG_W-1:0] control_word;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   always_comb begin
      hit_status = 1'b0;
      hit_control = 1'b0;
      if (REG_ADDR_I == `ADDR_EVENT_STATUS_AND_ENABLE) begin
         hit_status = 1'b1;
      end else if (REG_ADDR_I == `ADDR_GLOBAL_IRQ_CONTROL) begin
         hit_control = 1'b1;
      end
   end

   assign rd_status = REG_RD_I & hit_status;
   assign wr_status = REG_WR_I & hit_status;
   assign wr_control = REG_WR_I & hit_control;

   // ****************************************************************
   // Event routing into flag positions
   // ****************************************************************
   // Reserved control bit 3 always reads zero, so duplex stays selected
   assign duplex_selected = (`GIC_DUPLEX_SEL_VALUE == 1'h0);

   // Taken straight from the pin so the routing does not loop through the next state
   assign shared_sel = (PHY_CONTROL_TWO_SEL_I != '0);

   always_comb begin
      event_set = '0;
      // Raw events land here whatever the enables say
      event_set[`EVT_LINK_QUALITY] = LINK_QUALITY_EVT_I;
      event_set[`EVT_ENERGY_DETECT] = ENERGY_DETECT_EVT_I;
      event_set[`EVT_LINK_CHANGE] = LINK_CHANGE_EVT_I;
      event_set[`EVT_SPEED_CHANGE] = SPEED_CHANGE_EVT_I;
      event_set[`EVT_DUPLEX_CHANGE] = DUPLEX_CHANGE_EVT_I & duplex_selected;
      event_set[`EVT_AUTONEG_DONE] = AUTONEG_DONE_EVT_I;
      if (!shared_sel) begin
         event_set[`EVT_COUNTER_HALF] = FALSE_CARRIER_HALF_EVT_I;
         event_set[`EVT_RXERR_OR_FRAME] = RX_ERROR_HALF_EVT_I;
      end else begin
         event_set[`EVT_COUNTER_HALF] = FALSE_CARRIER_HALF_EVT_I | RX_ERROR_HALF_EVT_I;
         event_set[`EVT_RXERR_OR_FRAME] = CONTROL_FRAME_EVT_I;
      end
   end

   // A status read clears exactly the flags that it returns
   assign event_clear = rd_status ? pending : '0;

   // ****************************************************************
   // Sticky pending flags
   // ****************************************************************
   event_flag_bank #(
      .WIDTH(`EVT_COUNT)
   ) u_flags (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .set_i(event_set),
      .clear_i(event_clear),
      .flags_o(pending)
   );

   // Mirror of the bank's next value, used so the interrupt level is registered
   assign pending_next = event_set | (pending & ~event_clear);

   // ****************************************************************
   // Read words
   // ****************************************************************
   always_comb begin
      status_word = `EVT_RESET;
      status_word[`EVT_PENDING_LSB +: `EVT_COUNT] = pending;
      status_word[`EVT_ENABLE_LSB +: `EVT_COUNT] = s_q.enables;
   end

   always_comb begin
      control_word = `GIC_RESET;
      control_word[`GIC_TEST_IRQ_BIT] = s_q.test_irq;
      control_word[`GIC_EVENT_EN_BIT] = s_q.event_irq_en;
      control_word[`GIC_PIN_OE_BIT] = s_q.pin_oe;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      s_d.rvalid = REG_RD_I;

      // Selector followed every cycle; flags keep whatever meaning set them
      s_d.sel = shared_sel ? phy_irq_pkg::CNT_SEL_SHARED
                           : phy_irq_pkg::CNT_SEL_SPLIT;

      // Only the enable half of the status register is writable
      if (wr_status) begin
         s_d.enables = REG_WDATA_I[`EVT_ENABLE_LSB +: `EVT_COUNT];
      end

      // Reserved control bits ignore writes
      if (wr_control) begin
         s_d.test_irq = REG_WDATA_I[`GIC_TEST_IRQ_BIT];
         s_d.event_irq_en = REG_WDATA_I[`GIC_EVENT_EN_BIT];
         s_d.pin_oe = REG_WDATA_I[`GIC_PIN_OE_BIT];
      end

      // Unmapped reads return zero
      if (REG_RD_I) begin
         if (hit_status) begin
            s_d.rdata = status_word;
         end else if (hit_control) begin
            s_d.rdata = control_word;
         end else begin
            s_d.rdata = '0;
         end
      end

      // Interrupt needs both a per-event enable and the global enable, or the test bit alone
      any_enabled_pending = |(pending_next & s_d.enables);
      s_d.irq = s_d.test_irq | (s_d.event_irq_en & any_enabled_pending);
   end

   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign REG_RDATA_O = s_q.rdata;
   assign REG_RVALID_O = s_q.rvalid;
   assign IRQ_O = s_q.irq;

   // Pin is driven only as interrupt output; low means interrupt
   assign POWERDOWN_OR_IRQ_PIN_OE_O = s_q.pin_oe;
   assign POWERDOWN_OR_IRQ_PIN_N_O = ~s_q.irq;

   // As an input the pin requests power-down when pulled low
   assign POWER_DOWN_REQ_O = ~s_q.pin_oe & ~POWERDOWN_OR_IRQ_PIN_N_I;

endmodule // phy_event_interrupt_status

// ### hw/phy_irq_cfg.svh
// Register offsets, field positions and reset values of the event interrupt block
`ifndef PHY_IRQ_CFG_SVH
`define PHY_IRQ_CFG_SVH

// ****************************************************************
// Register offsets on the management port
// ****************************************************************
`define ADDR_W 5
`define ADDR_GLOBAL_IRQ_CONTROL 5'h11
`define ADDR_EVENT_STATUS_AND_ENABLE 5'h12
`define REG_W 16

// ****************************************************************
// Global control fields
// ****************************************************************
`define GIC_PIN_OE_BIT 0
`define GIC_EVENT_EN_BIT 1
`define GIC_TEST_IRQ_BIT 2
`define GIC_DUPLEX_SEL_BIT 3
`define GIC_RESET 16'h0000
// Bit 3 is reserved and reads zero, so the duplex function stays selected
`define GIC_DUPLEX_SEL_VALUE 1'h0

// ****************************************************************
// Event status and enable fields
// ****************************************************************
`define EVT_COUNT 8
`define EVT_PENDING_LSB 8
`define EVT_ENABLE_LSB 0
`define EVT_LINK_QUALITY 7
`define EVT_ENERGY_DETECT 6
`define EVT_LINK_CHANGE 5
`define EVT_SPEED_CHANGE 4
`define EVT_DUPLEX_CHANGE 3
`define EVT_AUTONEG_DONE 2
`define EVT_COUNTER_HALF 1
`define EVT_RXERR_OR_FRAME 0
`define EVT_RESET 16'h0000

// Selector field width of the second PHY control register
`define CTRL2_SEL_W 2

`endif

// ### hw/phy_irq_pkg.sv
// Types shared by the event interrupt block
package phy_irq_pkg;

   // ****************************************************************
   // Meaning of the two shared flag positions
   // ****************************************************************
   typedef enum logic [0:0] {
      CNT_SEL_SPLIT = 1'h0,
      CNT_SEL_SHARED = 1'h1
   } counter_sel_t;

   // ****************************************************************
   // State of the top module apart from the pending flags held in the flag bank
   // ****************************************************************
   typedef struct packed {
      logic test_irq;
      logic event_irq_en;
      logic pin_oe;
      logic [7:0] enables;
      logic [15:0] rdata;
      logic rvalid;
      logic irq;
      counter_sel_t sel;
   } ctrl_state_t;

endpackage

// ### hw/event_flag_bank.sv
// Sticky event flags where a new event wins over a clear
`timescale 1ns/1ps

module event_flag_bank #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clear_i,
   output logic [WIDTH-1:0] flags_o
);

   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } bank_state_t;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("event_flag_bank needs WIDTH of at least one");
      end
   endgenerate

   bank_state_t s_q;
   bank_state_t s_d;
   logic [WIDTH-1:0] next_flags;

   // ****************************************************************
   // Per-flag next value
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         // Set has priority so an event in the clearing cycle survives
         assign next_flags[i] = set_i[i] | (s_q.flags[i] & ~clear_i[i]);
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      s_d.flags = next_flags;
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flags_o = s_q.flags;

endmodule // event_flag_bank

// ### tb/host_pin_model.sv
// Host side of the shared power-down / interrupt pin
`timescale 1ns/1ps
module host_pin_model (
   input wire logic oe_i,
   input wire logic drive_n_i,
   input wire logic host_pd_n_i,
   output logic level_o
);
   // Host drives the pin only while the block leaves it an input
   assign level_o = oe_i ? drive_n_i : host_pd_n_i;
endmodule // host_pin_model

// ### tb/phy_event_interrupt_status_asserts.sv
// Port checker of the event interrupt block
`timescale 1ns/1ps
`include "phy_irq_cfg.svh"
module phy_irq_checker (
   input wire logic CLK_I,
   input wire logic RESETN_I,
   input wire logic [`ADDR_W-1:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [`REG_W-1:0] REG_WDATA_I,
   input wire logic [`REG_W-1:0] REG_RDATA_O,
   input wire logic REG_RVALID_O,
   input wire logic LINK_QUALITY_EVT_I,
   input wire logic LINK_CHANGE_EVT_I,
   input wire logic POWERDOWN_OR_IRQ_PIN_N_I,
   input wire logic POWERDOWN_OR_IRQ_PIN_N_O,
   input wire logic POWERDOWN_OR_IRQ_PIN_OE_O,
   input wire logic POWER_DOWN_REQ_O,
   input wire logic IRQ_O
);
   logic [7:0] en_q;
   logic [2:0] gc_q;
   wire rd_s = REG_RD_I && REG_ADDR_I == `ADDR_EVENT_STATUS_AND_ENABLE;
   wire rd_c = REG_RD_I && REG_ADDR_I == `ADDR_GLOBAL_IRQ_CONTROL;
   // Shadow of the writable fields
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         en_q <= 8'h00;
         gc_q <= 3'h0;
      end else if (REG_WR_I) begin
         if (REG_ADDR_I == `ADDR_EVENT_STATUS_AND_ENABLE) en_q <= REG_WDATA_I[7:0];
         if (REG_ADDR_I == `ADDR_GLOBAL_IRQ_CONTROL) gc_q <= REG_WDATA_I[2:0];
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   property p_rvalid; REG_RVALID_O == $past(REG_RD_I); endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
   property p_pin; POWERDOWN_OR_IRQ_PIN_OE_O |-> POWERDOWN_OR_IRQ_PIN_N_O == !IRQ_O; endproperty
   a_pin: assert property (p_pin) else $error("pin level differs from interrupt");
   property p_pd;
      POWER_DOWN_REQ_O == (!POWERDOWN_OR_IRQ_PIN_OE_O && !POWERDOWN_OR_IRQ_PIN_N_I);
   endproperty
   a_pd: assert property (p_pd) else $error("power-down request wrong");
   property p_oe; $stable(gc_q[0]) |-> POWERDOWN_OR_IRQ_PIN_OE_O == gc_q[0]; endproperty
   a_oe: assert property (p_oe) else $error("pin enable differs from control");
   property p_test; gc_q[2] && $past(gc_q[2]) |-> IRQ_O; endproperty
   a_test: assert property (p_test) else $error("test interrupt missing");
   property p_off; !gc_q[2] && !gc_q[1] && $stable(gc_q) |-> !IRQ_O; endproperty
   a_off: assert property (p_off) else $error("interrupt while disabled");
   property p_evt; LINK_CHANGE_EVT_I && en_q[5] && gc_q[1] && !REG_WR_I |=> IRQ_O; endproperty
   a_evt: assert property (p_evt) else $error("enabled event gave no interrupt");
   property p_set; LINK_CHANGE_EVT_I ##1 rd_s |=> REG_RDATA_O[13]; endproperty
   a_set: assert property (p_set) else $error("link change flag not set");
   property p_race; rd_s && LINK_QUALITY_EVT_I ##1 rd_s |=> REG_RDATA_O[15]; endproperty
   a_race: assert property (p_race) else $error("event lost in clearing read");
   property p_cor; rd_s && !LINK_QUALITY_EVT_I ##1 rd_s |=> !REG_RDATA_O[15]; endproperty
   a_cor: assert property (p_cor) else $error("flag not cleared by read");
   property p_en; rd_s |=> REG_RDATA_O[7:0] == $past(en_q); endproperty
   a_en: assert property (p_en) else $error("enable readback wrong");
   property p_ctl; rd_c |=> REG_RDATA_O == {13'h0000, $past(gc_q)}; endproperty
   a_ctl: assert property (p_ctl) else $error("control readback wrong");
   c_rd: cover property (rd_s ##1 REG_RVALID_O);
   c_irq: cover property ($rose(IRQ_O));
   c_pd: cover property (POWER_DOWN_REQ_O);
endmodule // phy_irq_checker
bind phy_event_interrupt_status phy_irq_checker chk_inst (.CLK_I, .RESETN_I, .REG_ADDR_I, .REG_WR_I,
   .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_RVALID_O, .LINK_QUALITY_EVT_I, .LINK_CHANGE_EVT_I,
   .POWERDOWN_OR_IRQ_PIN_N_I, .POWERDOWN_OR_IRQ_PIN_N_O, .POWERDOWN_OR_IRQ_PIN_OE_O,
   .POWER_DOWN_REQ_O, .IRQ_O);

// ### tb/phy_event_interrupt_status_tb_top.sv
// Self-checking bench of the event interrupt block
`timescale 1ns/1ps
`include "phy_irq_cfg.svh"
module phy_event_interrupt_status_tb_top;
   localparam logic [4:0] AS = `ADDR_EVENT_STATUS_AND_ENABLE;
   localparam logic [4:0] AC = `ADDR_GLOBAL_IRQ_CONTROL;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pd_n = 1'b1;
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic [1:0] sel = 2'h0;
   logic [8:0] evt = 9'h000;
   logic [15:0] rdata;
   logic [15:0] q[$];
   logic [7:0] en;
   logic rvalid, pin_o, oe, pdreq, irq, level;
   int err_count = 0;
   int cmp_count = 0;
   int seed = 26293;
   always #2.5 clk = ~clk;
   phy_event_interrupt_status phy_event_interrupt_status_inst (.CLK_I(clk), .RESETN_I(rstn),
      .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
      .REG_RVALID_O(rvalid), .PHY_CONTROL_TWO_SEL_I(sel), .LINK_QUALITY_EVT_I(evt[0]),
      .ENERGY_DETECT_EVT_I(evt[1]), .LINK_CHANGE_EVT_I(evt[2]), .SPEED_CHANGE_EVT_I(evt[3]),
      .DUPLEX_CHANGE_EVT_I(evt[4]), .AUTONEG_DONE_EVT_I(evt[5]), .FALSE_CARRIER_HALF_EVT_I(evt[6]),
      .RX_ERROR_HALF_EVT_I(evt[7]), .CONTROL_FRAME_EVT_I(evt[8]), .POWERDOWN_OR_IRQ_PIN_N_I(level),
      .POWERDOWN_OR_IRQ_PIN_N_O(pin_o), .POWERDOWN_OR_IRQ_PIN_OE_O(oe), .POWER_DOWN_REQ_O(pdreq),
      .IRQ_O(irq));
   host_pin_model host_pin_model_inst (.oe_i(oe), .drive_n_i(pin_o), .host_pd_n_i(pd_n), .level_o(level));
   task automatic check(logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      check(16'(q.size()), 16'h0000);
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One cycle from a falling edge; for a read, d is the expected answer
   task automatic op(logic r, logic w, logic [4:0] a, logic [15:0] d, logic [8:0] ev);
      rd = r;
      wr = w;
      addr = a;
      wdata = d;
      evt = ev;
      if (r) q.push_back(d);
      // Held until the next call so no strobe is assigned twice in one step
      @(negedge clk);
   endtask
   function automatic logic [15:0] flag(int i, logic [1:0] s);
      if (i == 8) return 16'h0100;
      if (i == 7 && s != 2'h0) return 16'h0200;
      return 16'h8000 >> i;
   endfunction
   always @(negedge clk) begin
      if (rvalid === 1'b1) check(rdata, q.size() > 0 ? q.pop_front() : 16'hDEAD);
   end
   initial begin
      #50000;
      err_count++;
      end_sim;
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      op(1, 0, AS, 16'h0000, 9'h000);
      op(1, 0, AC, 16'h0000, 9'h000);
      op(1, 0, 5'h05, 16'h0000, 9'h000);
      op(0, 1, AS, 16'hFFFF, 9'h000);
      op(1, 0, AS, 16'h00FF, 9'h000);
      op(0, 1, AC, 16'hFFFF, 9'h000);
      op(1, 0, AC, 16'h0007, 9'h000);
      check({14'h0000, oe, irq}, 16'h0003);
      op(0, 1, AC, 16'h0000, 9'h000);
      op(0, 0, AS, 16'h0000, 9'h000);
      check({15'h0000, irq}, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         sel = s[1:0];
         for (int i = 0; i < 9; i++) begin
            if (i == 8 && s == 0) continue;
            op(0, 0, AS, 16'h0000, 9'h001 << i);
            op(1, 0, AS, flag(i, sel) | 16'h00FF, 9'h000);
            op(1, 0, AS, 16'h00FF, 9'h000);
            check({15'h0000, irq}, 16'h0000);
         end
      end
      sel = 2'h0;
      en = 8'($random(seed)) | 8'h20;
      op(0, 1, AS, {8'h00, en}, 9'h000);
      op(0, 1, AC, 16'h0003, 9'h000);
      for (int i = 0; i < 8; i++) begin
         op(0, 0, AS, 16'h0000, 9'h001 << i);
         check({15'h0000, irq}, {15'h0000, en[7-i]});
         check({15'h0000, pin_o}, {15'h0000, !en[7-i]});
         op(1, 0, AS, flag(i, sel) | en, 9'h000);
         check({15'h0000, irq}, 16'h0000);
      end
      op(1, 0, AS, {8'h00, en}, 9'h001);
      op(1, 0, AS, 16'h8000 | en, 9'h000);
      op(0, 1, AC, 16'h0001, 9'h000);
      op(0, 0, AS, 16'h0000, 9'h004);
      check({15'h0000, irq}, 16'h0000);
      op(1, 0, AS, 16'h2000 | en, 9'h000);
      op(0, 1, AC, 16'h0000, 9'h000);
      pd_n = 1'b0;
      op(0, 0, AS, 16'h0000, 9'h000);
      check({15'h0000, pdreq}, 16'h0001);
      pd_n = 1'b1;
      repeat (3) @(negedge clk);
      end_sim;
   end
endmodule // phy_event_interrupt_status_tb_top
